// ---- core/ohr_pkg.sv ----
// shared constants and types for the display host interface and reset state
package ohr_pkg;
  // -----------------------------------------------------------------
  // synchroniser slots for the pins
  // -----------------------------------------------------------------
  localparam int SYNC_W = 15;
  localparam int SY_HWI = 0;
  localparam int SY_BS1 = 1;
  localparam int SY_BS2 = 2;
  localparam int SY_CS = 3;
  localparam int SY_DC = 4;
  localparam int SY_RW = 5;
  localparam int SY_E = 6;
  localparam int SY_D0 = 7;
  localparam int SY_D1 = 8;

  // -----------------------------------------------------------------
  // display memory geometry
  // -----------------------------------------------------------------
  localparam int COL_W = 7;
  localparam int PAGE_W = 3;
  localparam int RAM_AW = COL_W + PAGE_W;
  localparam int RAM_DEPTH = 1024;

  // -----------------------------------------------------------------
  // serial link constants
  // -----------------------------------------------------------------
  localparam logic [6:0] I2C_ADDR_BASE = 7'h3c;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // -----------------------------------------------------------------
  // values loaded by initialisation
  // -----------------------------------------------------------------
  localparam logic [7:0] CONTRAST_RST = 8'h7f;
  localparam logic [5:0] START_RST = 6'h00;
  localparam logic [COL_W-1:0] COL_RST = 7'h00;
  localparam logic [PAGE_W-1:0] PAGE_RST = 3'h0;
  localparam logic [5:0] MUX_RST = 6'h3f;

  // -----------------------------------------------------------------
  // command codes
  // -----------------------------------------------------------------
  localparam logic [7:0] CMD_CONTRAST = 8'h81;
  localparam logic [7:0] CMD_REMAP0 = 8'ha0;
  localparam logic [7:0] CMD_REMAP1 = 8'ha1;
  localparam logic [7:0] CMD_FOLLOW_RAM = 8'ha4;
  localparam logic [7:0] CMD_ALL_ON = 8'ha5;
  localparam logic [7:0] CMD_INV_OFF = 8'ha6;
  localparam logic [7:0] CMD_INV_ON = 8'ha7;
  localparam logic [7:0] CMD_MUX = 8'ha8;
  localparam logic [7:0] CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] CMD_DISP_ON = 8'haf;
  localparam logic [7:0] CMD_SCAN_NORM = 8'hc0;
  localparam logic [7:0] CMD_SCAN_REV = 8'hc8;

  typedef enum logic [1:0] {OHR_I2C, OHR_SPI, OHR_P80, OHR_P68} ohr_mode_e;
  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_CTRL, I_DATA, I_SKIP} ohr_i2c_e;
  typedef enum logic [1:0] {A_NONE, A_CONTRAST, A_MUX, A_SKIP} ohr_arg_e;
endpackage

// ---- core/ohr_disp_ram.sv ----
// display memory with one write port and one registered read port
`timescale 1ns/1ps
module ohr_disp_ram
  import ohr_pkg::*;
(
  // clock
  input wire logic clk_in,
  // write port
  input wire logic we_in,
  input wire logic [RAM_AW-1:0] waddr_in,
  input wire logic [7:0] wdata_in,
  // read port
  input wire logic [RAM_AW-1:0] raddr_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [RAM_DEPTH];

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  // write and registered read
  always_ff @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule

// ---- core/ohr_host_core.sv ----
// host interface, command decoder and initial state of the display controller
`timescale 1ns/1ps
module ohr_host_core
  import ohr_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // host pins
  input wire logic hw_init_low_in,
  input wire logic bs1_in,
  input wire logic bs2_in,
  input wire logic cs_n_in,
  input wire logic dc_in,
  input wire logic rw_wr_n_in,
  input wire logic e_rd_n_in,
  input wire logic [7:0] data_in,
  // open-drain acknowledge on bit 1
  output logic sda_out,
  output logic sda_oe_n_out,
  // panel state
  output logic display_on_out,
  output logic [7:0] contrast_out,
  output logic [5:0] start_line_out,
  output logic [5:0] mux_ratio_out,
  output logic seg_remap_out,
  output logic com_reverse_out,
  output logic entire_on_out,
  output logic inverse_out,
  output logic [COL_W-1:0] col_addr_out,
  output logic [PAGE_W-1:0] page_addr_out,
  // scan read port
  input wire logic [RAM_AW-1:0] scan_addr_in,
  output logic [7:0] scan_data_out
);
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] sy1_ff;
  logic [SYNC_W-1:0] sy_ff;
  logic [SYNC_W-1:0] prev_ff;
  logic init_w;
  ohr_mode_e mode;
  logic p_act;
  logic p_act_ff;
  logic [7:0] p_dat_ff;
  logic p_dc_ff;
  logic [7:0] s_sh_ff;
  logic [2:0] s_cnt_ff;
  ohr_i2c_e i_st_ff;
  logic [7:0] i_sh_ff;
  logic [2:0] i_cnt_ff;
  logic i_got8_ff;
  logic i_ack_ff;
  logic i_co_ff;
  logic i_dc_ff;
  logic scl_rise;
  logic scl_fall;
  logic i_start;
  logic i_stop;
  logic nxt_vld;
  logic [7:0] nxt_dat;
  logic nxt_dc;
  logic byte_vld_ff;
  logic [7:0] byte_dat_ff;
  logic byte_dc_ff;
  logic [1:0] arg_left_ff;
  ohr_arg_e arg_op_ff;
  logic ram_we;

  // number of argument bytes that follow a command code
  function automatic logic [1:0] cmd_args(input logic [7:0] c);
    if (c == 8'h21 || c == 8'h22)
      cmd_args = 2'h2;
    else if (c == CMD_CONTRAST || c == CMD_MUX || c == 8'hd3 || c == 8'hd5
             || c == 8'hd9 || c == 8'hda || c == 8'hdb || c == 8'h20
             || c == 8'had || c == 8'h8d)
      cmd_args = 2'h1;
    else
      cmd_args = 2'h0;
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  assign raw = {data_in, e_rd_n_in, rw_wr_n_in, dc_in, cs_n_in, bs2_in, bs1_in,
                hw_init_low_in};
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++)
    begin : g_sync
      // two flops per pin, then one more for edge finding
      always_ff @(posedge clk_in)
      begin
        if (!resetn_in)
        begin
          sy1_ff[g] <= 1'b0;
          sy_ff[g] <= 1'b0;
          prev_ff[g] <= 1'b0;
        end
        else
        begin
          sy1_ff[g] <= raw[g];
          sy_ff[g] <= sy1_ff[g];
          prev_ff[g] <= sy_ff[g];
        end
      end
    end
  endgenerate

  // init held while pin low; interface picked by straps
  assign init_w = !sy_ff[SY_HWI];
  assign mode = ohr_mode_e'({sy_ff[SY_BS2], !sy_ff[SY_BS1]});
  assign scl_rise = sy_ff[SY_D0] && !prev_ff[SY_D0];
  assign scl_fall = !sy_ff[SY_D0] && prev_ff[SY_D0];
  assign i_start = sy_ff[SY_D0] && prev_ff[SY_D0] && prev_ff[SY_D1] && !sy_ff[SY_D1];
  assign i_stop = sy_ff[SY_D0] && prev_ff[SY_D0] && !prev_ff[SY_D1] && sy_ff[SY_D1];

  // -----------------------------------------------------------------
  // parallel bus
  // -----------------------------------------------------------------
  // write strobe window: wr low (80) or e high with rw low (68)
  assign p_act = !sy_ff[SY_CS] && (mode == OHR_P80 ? !sy_ff[SY_RW]
                                 : (sy_ff[SY_E] && !sy_ff[SY_RW]));
  // keep the last bus value seen inside the window
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      p_act_ff <= 1'b0;
      p_dat_ff <= 8'h00;
      p_dc_ff <= 1'b0;
    end
    else
    begin
      p_act_ff <= p_act;
      if (p_act)
      begin
        p_dat_ff <= sy_ff[SY_D0 +: 8];
        p_dc_ff <= sy_ff[SY_DC];
      end
    end
  end

  // -----------------------------------------------------------------
  // spi receiver
  // -----------------------------------------------------------------
  // shift on clock rise, msb first; chip select high drops partial byte
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || init_w || sy_ff[SY_CS] || mode != OHR_SPI)
    begin
      s_sh_ff <= 8'h00;
      s_cnt_ff <= 3'h0;
    end
    else if (scl_rise)
    begin
      s_sh_ff <= {s_sh_ff[6:0], sy_ff[SY_D1]};
      s_cnt_ff <= s_cnt_ff + 3'h1;
    end
  end

  // -----------------------------------------------------------------
  // i2c receiver
  // -----------------------------------------------------------------
  // address, control byte, then data or command bytes with ack
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || init_w || mode != OHR_I2C)
    begin
      i_st_ff <= I_IDLE;
      i_sh_ff <= 8'h00;
      i_cnt_ff <= 3'h0;
      i_got8_ff <= 1'b0;
      i_ack_ff <= 1'b0;
      i_co_ff <= 1'b0;
      i_dc_ff <= 1'b0;
    end
    else if (i_start)
    begin
      i_st_ff <= I_ADDR;
      i_cnt_ff <= 3'h0;
      i_got8_ff <= 1'b0;
      i_ack_ff <= 1'b0;
    end
    else if (i_stop)
    begin
      i_st_ff <= I_IDLE;
      i_got8_ff <= 1'b0;
      i_ack_ff <= 1'b0;
    end
    else if (i_st_ff != I_IDLE && scl_rise && !i_ack_ff)
    begin
      i_sh_ff <= {i_sh_ff[6:0], sy_ff[SY_D1]};
      i_cnt_ff <= i_cnt_ff + 3'h1;
      i_got8_ff <= (i_cnt_ff == BIT_LAST);
    end
    else if (scl_fall && i_got8_ff)
    begin
      i_got8_ff <= 1'b0;
      case (i_st_ff)
        I_ADDR:
        begin
          // select bit comes from the data/command pin
          if (i_sh_ff == {I2C_ADDR_BASE[6:1], sy_ff[SY_DC], 1'b0})
          begin
            i_ack_ff <= 1'b1;
            i_st_ff <= I_CTRL;
          end
          else
          begin
            i_st_ff <= I_SKIP;
          end
        end
        I_CTRL:
        begin
          i_co_ff <= i_sh_ff[7];
          i_dc_ff <= i_sh_ff[6];
          i_ack_ff <= 1'b1;
          i_st_ff <= I_DATA;
        end
        I_DATA:
        begin
          i_ack_ff <= 1'b1;
          if (i_co_ff)
          begin
            i_st_ff <= I_CTRL;
          end
        end
        default:
        begin
          i_ack_ff <= 1'b0;
        end
      endcase
    end
    else if (scl_fall && i_ack_ff)
    begin
      i_ack_ff <= 1'b0;
    end
  end

  // ack pulls the line low; released otherwise
  assign sda_out = 1'b0;
  assign sda_oe_n_out = !i_ack_ff;

  // -----------------------------------------------------------------
  // byte merge
  // -----------------------------------------------------------------
  // one byte pulse from whichever interface is strapped
  always_comb
  begin
    nxt_vld = 1'b0;
    nxt_dat = 8'h00;
    nxt_dc = 1'b0;
    case (mode)
      OHR_SPI:
      begin
        nxt_vld = scl_rise && !sy_ff[SY_CS] && s_cnt_ff == BIT_LAST;
        nxt_dat = {s_sh_ff[6:0], sy_ff[SY_D1]};
        nxt_dc = sy_ff[SY_DC];
      end
      OHR_I2C:
      begin
        nxt_vld = scl_fall && i_got8_ff && i_st_ff == I_DATA && !i_start && !i_stop;
        nxt_dat = i_sh_ff;
        nxt_dc = i_dc_ff;
      end
      default:
      begin
        nxt_vld = p_act_ff && !p_act;
        nxt_dat = p_dat_ff;
        nxt_dc = p_dc_ff;
      end
    endcase
  end

  // registered byte; nothing passes while init is held
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || init_w)
    begin
      byte_vld_ff <= 1'b0;
      byte_dat_ff <= 8'h00;
      byte_dc_ff <= 1'b0;
    end
    else
    begin
      byte_vld_ff <= nxt_vld;
      byte_dat_ff <= nxt_dat;
      byte_dc_ff <= nxt_dc;
    end
  end

  // -----------------------------------------------------------------
  // command decoder and panel state
  // -----------------------------------------------------------------
  // init loads the documented defaults
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || init_w)
    begin
      display_on_out <= 1'b0;
      mux_ratio_out <= MUX_RST;
      seg_remap_out <= 1'b0;
      start_line_out <= START_RST;
      col_addr_out <= COL_RST;
      page_addr_out <= PAGE_RST;
      com_reverse_out <= 1'b0;
      contrast_out <= CONTRAST_RST;
      entire_on_out <= 1'b0;
      inverse_out <= 1'b0;
      arg_left_ff <= 2'h0;
      arg_op_ff <= A_NONE;
    end
    else if (byte_vld_ff && byte_dc_ff)
    begin
      // data byte: memory write, column steps; pending args kept
      col_addr_out <= col_addr_out + 7'h01;
    end
    else if (byte_vld_ff && arg_left_ff != 2'h0)
    begin
      if (arg_op_ff == A_CONTRAST)
        contrast_out <= byte_dat_ff;
      else if (arg_op_ff == A_MUX)
        mux_ratio_out <= byte_dat_ff[5:0];
      arg_left_ff <= arg_left_ff - 2'h1;
    end
    else if (byte_vld_ff)
    begin
      arg_left_ff <= cmd_args(byte_dat_ff);
      arg_op_ff <= byte_dat_ff == CMD_CONTRAST ? A_CONTRAST
                 : byte_dat_ff == CMD_MUX ? A_MUX : A_SKIP;
      if (byte_dat_ff[7:4] == 4'h0)
        col_addr_out[3:0] <= byte_dat_ff[3:0];
      else if (byte_dat_ff[7:4] == 4'h1)
        col_addr_out[6:4] <= byte_dat_ff[2:0];
      else if (byte_dat_ff[7:6] == 2'h1)
        start_line_out <= byte_dat_ff[5:0];
      else if (byte_dat_ff[7:3] == 5'h16)
        page_addr_out <= byte_dat_ff[2:0];
      else if (byte_dat_ff == CMD_REMAP0 || byte_dat_ff == CMD_REMAP1)
        seg_remap_out <= byte_dat_ff[0];
      else if (byte_dat_ff == CMD_FOLLOW_RAM || byte_dat_ff == CMD_ALL_ON)
        entire_on_out <= byte_dat_ff[0];
      else if (byte_dat_ff == CMD_INV_OFF || byte_dat_ff == CMD_INV_ON)
        inverse_out <= byte_dat_ff[0];
      else if (byte_dat_ff == CMD_DISP_OFF || byte_dat_ff == CMD_DISP_ON)
        display_on_out <= byte_dat_ff[0];
      else if (byte_dat_ff == CMD_SCAN_NORM || byte_dat_ff == CMD_SCAN_REV)
        com_reverse_out <= byte_dat_ff[3];
    end
  end

  // -----------------------------------------------------------------
  // display memory
  // -----------------------------------------------------------------
  assign ram_we = byte_vld_ff && byte_dc_ff;
  ohr_disp_ram u_ram (
    .clk_in(clk_in),
    .we_in(ram_we),
    .waddr_in({page_addr_out, col_addr_out}),
    .wdata_in(byte_dat_ff),
    .raddr_in(scan_addr_in),
    .rdata_out(scan_data_out)
  );

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_init;
    init_w;
  endsequence
  sequence s_contrast_cmd;
    byte_vld_ff && !byte_dc_ff && byte_dat_ff == CMD_CONTRAST && arg_left_ff == 2'h0 && !init_w;
  endsequence
  sequence s_contrast_arg;
    byte_vld_ff && !byte_dc_ff && arg_left_ff == 2'h1 && arg_op_ff == A_CONTRAST && !init_w;
  endsequence

  AST_INIT_OFF_FORMAT: assert property (s_init |=> !display_on_out && mux_ratio_out == 6'h3f)
    else $error("init did not force display off and 64 rows");
  AST_INIT_MAPPING: assert property (s_init |=> !seg_remap_out)
    else $error("init left segment remap on");
  AST_INIT_SHIFT_CLEAR: assert property (s_init |=> s_cnt_ff == 3'h0 && i_cnt_ff == 3'h0)
    else $error("serial shift state survived init");
  AST_INIT_START_LINE: assert property (s_init |=> start_line_out == 6'h00)
    else $error("start line not zero after init");
  AST_INIT_COLUMN: assert property (s_init |=> col_addr_out == 7'h00)
    else $error("column counter not zero after init");
  AST_INIT_SCAN: assert property (s_init |=> !com_reverse_out)
    else $error("common scan reversed after init");
  AST_INIT_CONTRAST: assert property (s_init |=> contrast_out == 8'h7f)
    else $error("contrast not 7f after init");
  AST_INIT_NORMAL: assert property (s_init |=> !entire_on_out && !inverse_out)
    else $error("display not in normal mode after init");
  AST_INIT_BLOCKS_HOST: assert property (s_init ##1 s_init |-> !byte_vld_ff && !ram_we)
    else $error("host byte accepted during init");
  AST_DATA_TO_RAM: assert property (byte_vld_ff && byte_dc_ff && !init_w |-> ram_we ##1
                                    col_addr_out == $past(col_addr_out) + 7'h01)
    else $error("data byte did not write memory and step column");
  AST_CONTRAST_CMD: assert property (s_contrast_cmd |=> arg_left_ff == 2'h1
                                     && arg_op_ff == A_CONTRAST)
    else $error("contrast command did not wait for its argument");
  AST_CONTRAST_SEQ: assert property (s_contrast_arg |=> contrast_out == $past(byte_dat_ff))
    else $error("contrast argument not loaded");
  AST_I2C_ACK_MATCH: assert property (i_st_ff == I_ADDR && i_got8_ff && scl_fall && !i_start
                                      && !i_stop && i_sh_ff == {6'h1e, sy_ff[SY_DC], 1'b0}
                                      |=> !sda_oe_n_out && i_st_ff == I_CTRL)
    else $error("matching address not acknowledged");
endmodule

// ---- tb/ohr_host_model.sv ----
// host-side pin driver for the display controller bench
`timescale 1ns/1ps
module ohr_host_model
(
  // clock and sensed data wire
  input wire logic clk_in,
  input wire logic sda_in,
  // host pins
  output logic hw_init_low_out,
  output logic bs1_out,
  output logic bs2_out,
  output logic cs_n_out,
  output logic dc_out,
  output logic rw_wr_n_out,
  output logic e_rd_n_out,
  output logic [7:0] data_out
);
  // -----------------------------------------------------------------
  // idle levels and helpers
  // -----------------------------------------------------------------
  // straps for 80-style bus, init held low until released
  initial
  begin
    hw_init_low_out = 1'b0;
    {bs1_out, bs2_out, cs_n_out, rw_wr_n_out} = 4'hf;
    // lines that do not matter while idle start at random levels
    dc_out = 1'($urandom);
    e_rd_n_out = 1'($urandom);
    data_out = 8'($urandom);
  end

  // wait for n rising edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // init pin level, then let the synchroniser settle
  task automatic set_init(input logic v);
    hw_init_low_out <= v;
    tick(6);
  endtask

  // strap change with the idle levels of that interface
  task automatic set_mode(input logic b1, input logic b2, input logic [1:0] rwe);
    {bs1_out, bs2_out, rw_wr_n_out, e_rd_n_out} <= {b1, b2, rwe};
    data_out <= (b1 & ~b2) ? 8'h03 : 8'h00;
    cs_n_out <= 1'b1;
    tick(6);
  endtask

  // panel supply settle wait, shortened to keep the run brief
  task automatic settle(input int n);
    tick(n);
  endtask

  // -----------------------------------------------------------------
  // transfers
  // -----------------------------------------------------------------
  // one parallel write, byte taken when the strobe window closes
  task automatic par(input logic p68, input logic d_c, input logic [7:0] b);
    cs_n_out <= 1'b0;
    dc_out <= d_c;
    data_out <= b;
    {rw_wr_n_out, e_rd_n_out} <= 2'b01;
    tick(4);
    {rw_wr_n_out, e_rd_n_out} <= p68 ? 2'b00 : 2'b11;
    tick(4);
    cs_n_out <= 1'b1;
    data_out <= ~b;
    {rw_wr_n_out, e_rd_n_out} <= p68 ? 2'b10 : 2'b11;
    tick(2);
  endtask

  // msb-first serial bits, data on bit 1 and clock on bit 0
  task automatic spi(input logic d_c, input logic [7:0] b, input int n, input logic keep);
    cs_n_out <= 1'b0;
    dc_out <= d_c;
    for (int i = 0; i < n; i++)
    begin
      data_out <= {6'h00, b[7 - i], 1'b0};
      tick(4);
      data_out[0] <= 1'b1;
      tick(4);
    end
    data_out[0] <= 1'b0;
    tick(4);
    cs_n_out <= keep ? 1'b0 : 1'b1;
    data_out[1] <= ~data_out[1];
    tick(4);
  endtask

  // one two-wire bit, data changes only while clock low
  task automatic i2c_bit(input logic v);
    data_out[1] <= v;
    tick(2);
    data_out[0] <= 1'b1;
    tick(4);
    data_out[0] <= 1'b0;
    tick(2);
  endtask

  // eight bits then release data and look for the device pulling it low
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i]);
    data_out[1] <= 1'b1;
    tick(2);
    data_out[0] <= 1'b1;
    tick(2);
    ack = (sda_in === 1'b0);
    tick(2);
    data_out[0] <= 1'b0;
    tick(5);
  endtask

  // start, address, then control byte and one command byte only if acknowledged, stop
  task automatic i2c(input logic sel, input logic [6:0] addr, input logic [7:0] b,
    output logic ack);
    logic a;
    cs_n_out <= 1'b0;
    dc_out <= sel;
    data_out[1:0] <= 2'b11;
    tick(8);
    data_out[1] <= 1'b0;
    tick(4);
    data_out[0] <= 1'b0;
    tick(2);
    i2c_byte({addr, 1'b0}, ack);
    if (ack)
    begin
      i2c_byte(8'h00, a);
      i2c_byte(b, a);
    end
    data_out[1] <= 1'b0;
    tick(2);
    data_out[0] <= 1'b1;
    tick(4);
    data_out[1] <= 1'b1;
    tick(4);
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the host interface and initial state
`timescale 1ns/1ps
module testbench;
  import ohr_pkg::*;
  logic clk_in, resetn_in, ack;
  logic [RAM_AW-1:0] scan_addr_in;
  logic hwi, bs1, bs2, cs_n, dc, rw, e_rd;
  logic [7:0] hd, scan_data_out, ra, rb;
  logic [7:0] q[$];
  logic sda_out, sda_oe_n_out, display_on_out, seg_remap_out, com_reverse_out;
  logic entire_on_out, inverse_out;
  logic [7:0] contrast_out;
  logic [5:0] start_line_out, mux_ratio_out;
  logic [COL_W-1:0] col_addr_out;
  logic [PAGE_W-1:0] page_addr_out;
  int mismatches, tests_run, r;
  int e_dsp, e_con, e_mux, e_st, e_rm, e_rv, e_all, e_inv, e_col, e_pg, arg;
  logic [7:0] mem [int];
  // open-drain data wire, pulled up unless the device acknowledges
  wire logic sda_w = sda_oe_n_out ? 1'b1 : sda_out;
  wire logic [7:0] pin_d = {hd[7:2], hd[1] & sda_w, hd[0]};

  // -----------------------------------------------------------------
  // clock, host and design
  // -----------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  ohr_host_model host_u (.clk_in(clk_in), .sda_in(pin_d[1]), .hw_init_low_out(hwi),
    .bs1_out(bs1), .bs2_out(bs2), .cs_n_out(cs_n), .dc_out(dc), .rw_wr_n_out(rw),
    .e_rd_n_out(e_rd), .data_out(hd));

  ohr_host_core dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .hw_init_low_in(hwi),
    .bs1_in(bs1), .bs2_in(bs2), .cs_n_in(cs_n), .dc_in(dc), .rw_wr_n_in(rw),
    .e_rd_n_in(e_rd), .data_in(pin_d), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .display_on_out(display_on_out), .contrast_out(contrast_out),
    .start_line_out(start_line_out), .mux_ratio_out(mux_ratio_out),
    .seg_remap_out(seg_remap_out), .com_reverse_out(com_reverse_out),
    .entire_on_out(entire_on_out), .inverse_out(inverse_out), .col_addr_out(col_addr_out),
    .page_addr_out(page_addr_out), .scan_addr_in(scan_addr_in), .scan_data_out(scan_data_out));

  // -----------------------------------------------------------------
  // reference model
  // -----------------------------------------------------------------
  // state after initialisation
  task automatic m_init();
    e_dsp = 0;
    e_con = 'h7f;
    e_mux = 'h3f;
    {e_st, e_rm, e_rv, e_all, e_inv, e_col, e_pg, arg} = '0;
  endtask

  // one received byte: memory write or command decode
  task automatic m_byte(input logic d_c, input logic [7:0] b);
    if (d_c)
    begin
      mem[e_pg * 128 + e_col] = b;
      e_col = (e_col + 1) % 128;
    end
    else if (arg == 1)
      {e_con, arg} = {24'h0, b, 32'h0};
    else if (arg == 2)
      {e_mux, arg} = {26'h0, b[5:0], 32'h0};
    else if (b == 8'h81)
      arg = 1;
    else if (b == 8'ha8)
      arg = 2;
    else if (b[7:1] == 7'h57)
      e_dsp = b[0];
    else if (b[7:1] == 7'h50)
      e_rm = b[0];
    else if (b[7:1] == 7'h52)
      e_all = b[0];
    else if (b[7:1] == 7'h53)
      e_inv = b[0];
    else if (b == 8'hc0 || b == 8'hc8)
      e_rv = b[3];
    else if (b[7:6] == 2'b01)
      e_st = b[5:0];
    else if (b[7:4] == 4'h0)
      e_col = (e_col & 'h70) | b[3:0];
    else if (b[7:4] == 4'h1)
      e_col = (e_col & 'h0f) | (b[2:0] << 4);
    else if (b[7:3] == 5'h16)
      e_pg = b[2:0];
  endtask

  // -----------------------------------------------------------------
  // compares, transfers, closing
  // -----------------------------------------------------------------
  task automatic check_state();
    logic [34:0] got, exp;
    host_u.tick(8);
    got = {display_on_out, contrast_out, start_line_out, mux_ratio_out, seg_remap_out,
      com_reverse_out, entire_on_out, inverse_out, col_addr_out, page_addr_out};
    exp = {e_dsp[0], e_con[7:0], e_st[5:0], e_mux[5:0], e_rm[0], e_rv[0], e_all[0], e_inv[0],
      e_col[6:0], e_pg[2:0]};
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t state got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_v(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  // read one memory byte through the scan port
  task automatic check_mem(input int pg, input int col);
    scan_addr_in <= 10'(pg * 128 + col);
    host_u.tick(3);
    check_v(scan_data_out, mem[pg * 128 + col]);
  endtask

  // 0 = 80-style, 1 = 68-style, 2 = serial
  task automatic send(input int how, input logic d_c, input logic [7:0] b);
    if (how == 2)
      host_u.spi(d_c, b, 8, 1'b0);
    else
      host_u.par(how[0], d_c, b);
    m_byte(d_c, b);
  endtask

  task automatic end_test(input string n);
    $display("test %s done", n);
  endtask

  task automatic report_and_stop();
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog over the whole run
  initial
  begin
    #1000000;
    mismatches++;
    report_and_stop();
  end

  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial
  begin
    r = $urandom(3);
    resetn_in = 1'b0;
    scan_addr_in = 10'($urandom);
    m_init();
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    check_state();
    host_u.set_init(1'b1);
    end_test("reset");
    ra = 8'($urandom);
    rb = 8'($urandom);
    send(0, 1'b0, 8'hae);
    for (int i = 0; i < 4; i++)
      send(0, 1'b1, 8'h00);
    host_u.settle(40);
    q = '{8'haf, 8'h81, ra, 8'ha1, 8'hc8, 8'ha7, 8'ha5, 8'h40 | rb[5:0], 8'hb2, 8'h05, 8'h10};
    foreach (q[i])
      send(0, 1'b0, q[i]);
    send(0, 1'b1, 8'hae);
    send(0, 1'b1, rb);
    check_state();
    check_mem(2, 5);
    end_test("par80");
    host_u.set_mode(1'b0, 1'b1, 2'b10);
    q = '{8'ha0, 8'hc0, 8'ha6, 8'ha4, 8'h81, ~ra, 8'ha8, {2'b00, rb[5:0]}, 8'h7f, 8'h17,
      8'h0f};
    foreach (q[i])
      send(1, 1'b0, q[i]);
    send(1, 1'b1, ra);
    check_state();
    check_mem(2, 127);
    end_test("par68");
    host_u.set_init(1'b0);
    host_u.par(1'b1, 1'b1, 8'h55);
    host_u.par(1'b1, 1'b0, 8'h81);
    host_u.par(1'b1, 1'b0, 8'h00);
    host_u.set_init(1'b1);
    m_init();
    check_state();
    check_mem(0, 0);
    end_test("init");
    host_u.set_mode(1'b0, 1'b0, 2'b00);
    host_u.spi(1'b0, 8'haf, 5, 1'b1);
    host_u.set_init(1'b0);
    host_u.set_init(1'b1);
    send(2, 1'b0, 8'haf);
    host_u.spi(1'b0, 8'h81, 3, 1'b0);
    send(2, 1'b0, 8'h81);
    send(2, 1'b0, rb);
    send(2, 1'b1, ra);
    check_state();
    check_mem(0, 0);
    end_test("serial");
    host_u.set_mode(1'b1, 1'b0, 2'b00);
    for (int k = 0; k < 4; k++)
    begin
      host_u.i2c(k[1], {6'h1e, k[0]}, {7'h53, ~k[1]}, ack);
      check_v({7'h00, ack}, {7'h00, k[0] == k[1]});
      if (k[0] == k[1])
        m_byte(1'b0, {7'h53, ~k[1]});
    end
    check_state();
    end_test("twowire");
    host_u.i2c(1'b1, 7'h3d, 8'hae, ack);
    m_byte(1'b0, 8'hae);
    host_u.settle(40);
    check_state();
    resetn_in <= 1'b0;
    host_u.tick(3);
    resetn_in <= 1'b1;
    m_init();
    check_state();
    end_test("powerdown");
    report_and_stop();
  end
endmodule
